// ### logic/pio_top.v
// positioning i/o interpretation: start, mode, point select, status and analog scaling
// What this block does
// - auto mode: reverse start runs one move
// - jog: reverse rotation while start held
// - reverse motion decrements position address
// - mode input high selects automatic mode
// - two select inputs choose point entry
// - rough match when remaining within range
// - rough match off while base off
// - rough match asserted on servo-on entry
// - in-position while droop within range
// - in-position asserted on servo-on entry
// - trouble off on power/protective shutoff
// - trouble on within delay after power-on
// - ready only when servo on, amp ready
// - override: min 0, mid 100, full 199 percent
// - torque limit 10 bit, only when enabled
// - two monitors show selected quantity, 8 bit
// - only one serial interface enabled
// - software maps extra functions onto pins
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "pio_defs.vh"
module pio_top #(
  parameter READY_CYCLES = `PIO_READY_CYCLES,
  parameter DB_CYCLES = `PIO_DEBOUNCE_CYCLES,
  parameter POS_W = 16
) (
  // clock and reset
  input wire clk_sys_in,
  input wire rst_in,
  // register port
  input wire [3:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [15:0] reg_rdata_out,
  // discrete inputs
  input wire reverse_start_in,
  input wire auto_manual_select_in,
  input wire point_select_bit0_in,
  input wire point_select_bit1_in,
  input wire [3:0] aux_pins_in,
  // analog samples
  input wire [9:0] speed_override_in,
  input wire [9:0] analog_torque_limit_in,
  // discrete outputs
  output reg rough_match_out,
  output reg in_position_out,
  output reg trouble_out,
  output reg ready_out,
  output reg [1:0] aux_pins_out,
  // motion, analog and serial enable outputs
  output reg jog_reverse_out,
  output reg move_step_out,
  output reg [7:0] speed_percent_out,
  output reg [9:0] torque_limit_out,
  output reg [7:0] analog_monitor_a_out,
  output reg [7:0] analog_monitor_b_out,
  output reg serial_diff_en_out,
  output reg serial_single_en_out
);
  // ----------------------------------------
  // move sequencer states
  // ----------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_MOVE = 2'b10;
  // ----------------------------------------
  // input conditioning
  // ----------------------------------------
  reg [3:0] s1_q;
  reg [3:0] s2_q;
  reg [3:0] clean_q;
  reg [7:0] db_cnt_q;
  reg start_prev_q;
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      clean_q <= 4'h0;
      db_cnt_q <= 8'h00;
      start_prev_q <= 1'b0;
    end
    else
    begin
      s1_q <= {point_select_bit1_in, point_select_bit0_in, auto_manual_select_in,
        reverse_start_in};
      s2_q <= s1_q;
      start_prev_q <= clean_q[0];
      // a change must stay put for DB_CYCLES edges before it counts
      if (s2_q == clean_q)
        db_cnt_q <= 8'h00;
      else if (db_cnt_q == DB_CYCLES[7:0] - 8'h01)
      begin
        clean_q <= s2_q;
        db_cnt_q <= 8'h00;
      end
      else
        db_cnt_q <= db_cnt_q + 8'h01;
    end
  end
  wire start_lvl = clean_q[0];
  wire start_edge = clean_q[0] & ~start_prev_q;
  wire auto_mode = clean_q[1];
  wire [1:0] point_idx = clean_q[3:2];
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [3:0] ctrl_q;
  reg [POS_W-1:0] table_q [0:3];
  reg [POS_W-1:0] rough_q;
  reg [POS_W-1:0] inpos_q;
  reg [POS_W-1:0] err_q;
  reg [1:0] monsel_q;
  reg sersel_q;
  reg [3:0] map_q;
  integer i;
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl_q <= 4'h0;
      for (i = 0; i < 4; i = i + 1)
        table_q[i] <= {POS_W{1'b0}};
      rough_q <= `PIO_RST_ROUGH;
      inpos_q <= `PIO_RST_INPOS;
      err_q <= {POS_W{1'b0}};
      monsel_q <= 2'h0;
      sersel_q <= 1'b0;
      map_q <= 4'h0;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        `PIO_REG_CTRL: ctrl_q <= reg_wdata_in[3:0];
        `PIO_REG_TABLE0: table_q[0] <= reg_wdata_in;
        `PIO_REG_TABLE1: table_q[1] <= reg_wdata_in;
        `PIO_REG_TABLE2: table_q[2] <= reg_wdata_in;
        `PIO_REG_TABLE3: table_q[3] <= reg_wdata_in;
        `PIO_REG_ROUGH: rough_q <= reg_wdata_in;
        `PIO_REG_INPOS: inpos_q <= reg_wdata_in;
        `PIO_REG_ERR: err_q <= reg_wdata_in;
        `PIO_REG_MONSEL: monsel_q <= reg_wdata_in[1:0];
        `PIO_REG_SERSEL: sersel_q <= reg_wdata_in[0];
        `PIO_REG_MAP: map_q <= reg_wdata_in[3:0];
        default: ;
      endcase
    end
  end
  wire servo_on = ctrl_q[`PIO_CTRL_SERVO_ON];
  wire amp_ready = ctrl_q[`PIO_CTRL_AMP_READY];
  wire protect = ctrl_q[`PIO_CTRL_PROTECT];
  wire ext_limit = ctrl_q[`PIO_CTRL_EXT_LIMIT];
  wire base_on = servo_on & ~protect;
  // ----------------------------------------
  // motion: one move per edge, or jog
  // ----------------------------------------
  reg [1:0] state_q;
  reg [POS_W-1:0] remain_q;
  reg [POS_W-1:0] pos_q;
  reg servo_prev_q;
  // jog only from idle so it never overlaps an auto move
  wire jog = ~auto_mode & start_lvl & base_on & (state_q == ST_IDLE);
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q <= ST_IDLE;
      remain_q <= {POS_W{1'b0}};
      pos_q <= {POS_W{1'b0}};
      servo_prev_q <= 1'b0;
    end
    else
    begin
      servo_prev_q <= base_on;
      case (state_q)
        ST_IDLE:
        begin
          if (auto_mode & start_edge & base_on)
          begin
            remain_q <= table_q[point_idx];
            state_q <= ST_MOVE;
          end
          else if (jog)
            pos_q <= pos_q - {{(POS_W-1){1'b0}}, 1'b1};
        end
        ST_MOVE:
        begin
          if (!base_on || remain_q == {POS_W{1'b0}})
            state_q <= ST_IDLE;
          else
          begin
            remain_q <= remain_q - {{(POS_W-1){1'b0}}, 1'b1};
            pos_q <= pos_q - {{(POS_W-1){1'b0}}, 1'b1};
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // power-on delay for trouble output
  // ----------------------------------------
  // counts once after reset; trouble waits for it
  reg [31:0] pwr_cnt_q;
  reg pwr_done_q;
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pwr_cnt_q <= 32'h0;
      pwr_done_q <= 1'b0;
    end
    else if (!pwr_done_q)
    begin
      if (pwr_cnt_q >= READY_CYCLES - 1)
        pwr_done_q <= 1'b1;
      else
        pwr_cnt_q <= pwr_cnt_q + 32'h1;
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // ----------------------------------------
  // status helpers
  // ----------------------------------------
  // servo entry pulse forces the match outputs for one cycle
  wire servo_rise = base_on & ~servo_prev_q;
  // 0..1023 scaled by 200/1024: 0, 100 and 199 percent
  wire [17:0] speed_prod = {8'h00, speed_override_in} * 18'h0C8;
  // ----------------------------------------
  // monitor source selection
  // ----------------------------------------
  reg [7:0] monitor_a;
  reg [7:0] monitor_b;
  always @*
  begin
    monitor_a = pos_q[7:0];
    monitor_b = remain_q[7:0];
    case (monsel_q)
      2'h0:
      begin
        monitor_a = pos_q[7:0];
        monitor_b = remain_q[7:0];
      end
      2'h1:
      begin
        monitor_a = remain_q[7:0];
        monitor_b = err_q[7:0];
      end
      2'h2:
      begin
        monitor_a = err_q[7:0];
        monitor_b = pos_q[7:0];
      end
      default:
      begin
        monitor_a = speed_override_in[9:2];
        monitor_b = analog_torque_limit_in[9:2];
      end
    endcase
  end
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rough_match_out <= 1'b0;
      in_position_out <= 1'b0;
      trouble_out <= 1'b0;
      ready_out <= 1'b0;
      aux_pins_out <= 2'h0;
      jog_reverse_out <= 1'b0;
      move_step_out <= 1'b0;
      speed_percent_out <= 8'h00;
      torque_limit_out <= 10'h3FF;
      analog_monitor_a_out <= 8'h00;
      analog_monitor_b_out <= 8'h00;
      serial_diff_en_out <= 1'b0;
      serial_single_en_out <= 1'b0;
    end
    else
    begin
      // both match outputs are held low while the base circuit is off
      rough_match_out <= base_on & (servo_rise | (remain_q <= rough_q));
      in_position_out <= base_on & (servo_rise | (err_q <= inpos_q));
      // protective shutoff drops trouble at once
      trouble_out <= pwr_done_q & ~protect;
      ready_out <= servo_on & amp_ready & ~protect;
      // aux outputs mirror last cycle's registered status, except bit 0 shows the debounced mode input when map bit 2 is set
      aux_pins_out <= {map_q[3] ? in_position_out : ready_out,
        map_q[2] ? auto_mode : rough_match_out};
      jog_reverse_out <= jog;
      move_step_out <= (state_q == ST_MOVE) & base_on & (remain_q != {POS_W{1'b0}});
      speed_percent_out <= speed_prod[17:10];
      // torque limit falls back to full scale when external limit is off
      torque_limit_out <= ext_limit ? analog_torque_limit_in : 10'h3FF;
      analog_monitor_a_out <= monitor_a;
      analog_monitor_b_out <= monitor_b;
      serial_diff_en_out <= ~sersel_q;
      serial_single_en_out <= sersel_q;
    end
  end
  // ----------------------------------------
  // read port
  // ----------------------------------------
  // read data stands in the cycle after each cycle that the read strobe is high, zero otherwise
  reg [15:0] rdata;
  always @*
  begin
    rdata = 16'h0000;
    case (reg_addr_in)
      `PIO_REG_CTRL: rdata = {12'h000, ctrl_q};
      `PIO_REG_TABLE0: rdata = table_q[0];
      `PIO_REG_TABLE1: rdata = table_q[1];
      `PIO_REG_TABLE2: rdata = table_q[2];
      `PIO_REG_TABLE3: rdata = table_q[3];
      `PIO_REG_ROUGH: rdata = rough_q;
      `PIO_REG_INPOS: rdata = inpos_q;
      `PIO_REG_ERR: rdata = err_q;
      `PIO_REG_MONSEL: rdata = {14'h0, monsel_q};
      `PIO_REG_SERSEL: rdata = {15'h0, sersel_q};
      `PIO_REG_MAP: rdata = {12'h000, map_q};
      `PIO_REG_STATUS:
        rdata = {4'h0, aux_pins_in, state_q, clean_q, ready_out, trouble_out};
      `PIO_REG_POS: rdata = pos_q;
      `PIO_REG_REMAIN: rdata = remain_q;
      `PIO_REG_SCALED: rdata = {8'h00, speed_percent_out};
      default: rdata = 16'h0000;
    endcase
  end
  always @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      reg_rdata_out <= 16'h0000;
    else if (reg_rd_in)
      reg_rdata_out <= rdata;
    else
      reg_rdata_out <= 16'h0000;
  end
endmodule
`default_nettype wire

// ### logic/pio_defs.vh
// constants for the positioning i/o signal logic
`ifndef PIO_DEFS_VH
`define PIO_DEFS_VH
// register offsets
`define PIO_REG_CTRL 4'h0
`define PIO_REG_TABLE0 4'h1
`define PIO_REG_TABLE1 4'h2
`define PIO_REG_TABLE2 4'h3
`define PIO_REG_TABLE3 4'h4
`define PIO_REG_ROUGH 4'h5
`define PIO_REG_INPOS 4'h6
`define PIO_REG_ERR 4'h7
`define PIO_REG_MONSEL 4'h8
`define PIO_REG_SERSEL 4'h9
`define PIO_REG_MAP 4'hA
`define PIO_REG_STATUS 4'hB
`define PIO_REG_POS 4'hC
`define PIO_REG_REMAIN 4'hD
`define PIO_REG_SCALED 4'hE
// control register fields
`define PIO_CTRL_SERVO_ON 0
`define PIO_CTRL_AMP_READY 1
`define PIO_CTRL_PROTECT 2
`define PIO_CTRL_EXT_LIMIT 3
// reset values
`define PIO_RST_ROUGH 16'h0010
`define PIO_RST_INPOS 16'h0004
// timing
`define PIO_CLK_HZ 20000000
`define PIO_READY_DELAY_MS 1000
`define PIO_READY_CYCLES ((`PIO_CLK_HZ / 1000) * `PIO_READY_DELAY_MS)
`define PIO_DEBOUNCE_CYCLES 16
`endif

// ### testbench/pio_monitor.sv
// port-level assertion checker for the positioning i/o logic
`timescale 1ns/1ns
`default_nettype none
module pio_monitor #(
  parameter READY_CYCLES = 10
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // watched ports
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [9:0] speed_override_in,
  input wire logic [9:0] analog_torque_limit_in,
  input wire logic [7:0] speed_percent_out,
  input wire logic [9:0] torque_limit_out,
  input wire logic serial_diff_en_out,
  input wire logic serial_single_en_out,
  input wire logic jog_reverse_out,
  input wire logic move_step_out,
  input wire logic trouble_out,
  input wire logic in_position_out,
  input wire logic ready_out,
  input wire logic [1:0] aux_pins_out
);
  // ----------------------------------------
  // cycles since reset release
  // ----------------------------------------
  integer age_q;
  always @(posedge clk_sys_in or posedge rst_in)
    if (rst_in)
      age_q <= 0;
    else if (age_q < READY_CYCLES)
      age_q <= age_q + 1;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  sequence s_no_read;
    !reg_rd_in;
  endsequence
  rdata_idle_a: assert property (s_no_read |=> reg_rdata_out == 16'h0000)
    else $error("read data not zero outside a read");
  speed_scale_a: assert property (!$past(rst_in) |->
    speed_percent_out == 8'((18'($past(speed_override_in)) * 18'h0C8) >> 10))
    else $error("speed percent wrong");
  torque_src_a: assert property (!$past(rst_in) |-> torque_limit_out == 10'h3FF ||
    torque_limit_out == $past(analog_torque_limit_in)) else $error("torque limit wrong");
  serial_one_a: assert property (!(serial_diff_en_out && serial_single_en_out))
    else $error("both serial ports enabled");
  serial_cause_a: assert property ($changed(serial_single_en_out) |->
    $past(reg_wr_in) || $past(reg_wr_in, 2)) else $error("serial choice moved alone");
  motion_excl_a: assert property (jog_reverse_out |-> !move_step_out)
    else $error("jog and move together");
  trouble_wait_a: assert property (age_q < READY_CYCLES - 2 |-> !trouble_out)
    else $error("trouble output too early");
  aux_map_a: assert property (!$past(rst_in) |-> aux_pins_out[1] == $past(in_position_out) ||
    aux_pins_out[1] == $past(ready_out)) else $error("aux output source wrong");
endmodule
bind pio_top pio_monitor #(.READY_CYCLES(READY_CYCLES)) u_mon (.*);
`default_nettype wire

// ### testbench/pio_switch_model.sv
// operator switch model driving the discrete inputs, with contact chatter
`timescale 1ns/1ns
`default_nettype none
module pio_switch_model (
  // clock and wishes
  input wire logic clk_in,
  input wire logic press_in,
  input wire logic auto_in,
  input wire logic [1:0] idx_in,
  // contacts
  output var logic start_out = 1'b0,
  output var logic auto_out = 1'b0,
  output var logic [1:0] sel_out = 2'h0
);
  logic press_q = 1'b0;
  logic [1:0] chat_q = 2'h0;
  // ----------------------------------------
  // only the start contact chatters, three cycles per change
  // ----------------------------------------
  always @(posedge clk_in)
  begin
    press_q <= press_in;
    if (press_in != press_q)
      chat_q <= 2'h3;
    else if (chat_q != 2'h0)
      chat_q <= chat_q - 2'h1;
    start_out <= (chat_q != 2'h0) ? ~start_out : press_q;
    auto_out <= auto_in;
    sel_out <= idx_in;
  end
endmodule
`default_nettype wire

// ### testbench/pio_top_tb.sv
// self-checking bench for the positioning i/o logic
`timescale 1ns/1ns
`default_nettype none
`include "pio_defs.vh"
module pio_top_tb;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic press = 1'b0;
  logic auto = 1'b0;
  logic [1:0] idx = 2'h0;
  logic [3:0] aux = 4'h0;
  logic [9:0] spd = 10'h000;
  logic [9:0] tq = 10'h000;
  wire [15:0] rdata;
  wire start, mode, rough, inpos, trouble, ready, jog, step, sdiff, ssing;
  wire [1:0] sel;
  wire [7:0] spct, mona, monb;
  wire [9:0] tlim;
  integer err_count = 0;
  integer checks_done = 0;
  logic [15:0] tbl [4];
  logic [15:0] p0, p1;
  integer i, n;
  // ----------------------------------------
  // clock, models, helpers
  // ----------------------------------------
  initial
  begin
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  pio_switch_model u_sw (.clk_in(clk_sys_in), .press_in(press), .auto_in(auto), .idx_in(idx),
    .start_out(start), .auto_out(mode), .sel_out(sel));
  pio_top #(.READY_CYCLES(10), .DB_CYCLES(4)) u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .reverse_start_in(start), .auto_manual_select_in(mode),
    .point_select_bit0_in(sel[0]), .point_select_bit1_in(sel[1]), .aux_pins_in(aux),
    .speed_override_in(spd), .analog_torque_limit_in(tq), .rough_match_out(rough),
    .in_position_out(inpos), .trouble_out(trouble), .ready_out(ready), .aux_pins_out(),
    .jog_reverse_out(jog), .move_step_out(step), .speed_percent_out(spct),
    .torque_limit_out(tlim), .analog_monitor_a_out(mona), .analog_monitor_b_out(monb),
    .serial_diff_en_out(sdiff), .serial_single_en_out(ssing));
  function automatic logic [15:0] exp_speed(input integer v);
    return 16'(v * 200 / 1024);
  endfunction
  task automatic cyc(input integer k);
    repeat (k) @(posedge clk_sys_in);
  endtask
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    cyc(1);
    d = rdata;
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #300000;
    err_count++;
    complete_run();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    void'($urandom(3741));
    cyc(6);
    rst_in <= 1'b0;
    aux <= 4'($urandom);
    cyc(2);
    chk("serial diff", 16'h0001, 16'(sdiff));
    rd_reg(`PIO_REG_ROUGH, p0);
    chk("rough range", 16'h0010, p0);
    rd_reg(`PIO_REG_INPOS, p0);
    chk("inpos range", 16'h0004, p0);
    rd_reg(4'hF, p0);
    chk("unmapped", 16'h0000, p0);
    cyc(10);
    chk("trouble on", 16'h0001, 16'(trouble));
    wr_reg(`PIO_REG_SERSEL, 16'h0001);
    cyc(3);
    chk("serial single", 16'h0002, {14'h0, ssing, sdiff});
    wr_reg(`PIO_REG_ERR, 16'h0123);
    wr_reg(`PIO_REG_CTRL, 16'h0003);
    cyc(1);
    chk("servo on flags", 16'h0003, {14'h0, rough, inpos});
    cyc(1);
    chk("inpos after entry", 16'h0000, 16'(inpos));
    chk("ready", 16'h0001, 16'(ready));
    for (i = 0; i < 4; i++)
    begin
      tbl[i] = (i == 3) ? 16'h0001 : 16'h0001 + 16'($urandom % 30);
      wr_reg(`PIO_REG_TABLE0 + 4'(i), tbl[i]);
    end
    auto <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      idx <= 2'(i);
      cyc(30);
      rd_reg(`PIO_REG_POS, p0);
      press <= 1'b1;
      repeat (60) if (step !== 1'b1) cyc(1);
      repeat (60) if (step === 1'b1) cyc(1);
      press <= 1'b0;
      cyc(30);
      rd_reg(`PIO_REG_POS, p1);
      chk("auto distance", tbl[i], p0 - p1);
      chk("rough at end", 16'h0001, 16'(rough));
    end
    auto <= 1'b0;
    cyc(30);
    rd_reg(`PIO_REG_POS, p0);
    press <= 1'b1;
    cyc(40);
    chk("jog on", 16'h0001, 16'(jog));
    press <= 1'b0;
    cyc(30);
    chk("jog off", 16'h0000, 16'(jog));
    rd_reg(`PIO_REG_POS, p1);
    chk("jog lowers", 16'h0001, 16'(p1 < p0));
    for (i = 0; i < 3; i++)
    begin
      wr_reg(`PIO_REG_MONSEL, 16'(i));
      cyc(1);
      chk("monitor a", (i == 0) ? 16'(p1[7:0]) : (i == 1) ? 16'h0000 : 16'h0023, 16'(mona));
      chk("monitor b", (i == 0) ? 16'h0000 : (i == 1) ? 16'h0023 : 16'(p1[7:0]), 16'(monb));
    end
    wr_reg(`PIO_REG_MONSEL, 16'h0003);
    for (i = 0; i < 6; i++)
    begin
      n = (i == 0) ? 0 : (i == 1) ? 512 : (i == 2) ? 1023 : $urandom % 1024;
      spd <= 10'(n);
      tq <= 10'($urandom % 1024);
      wr_reg(`PIO_REG_CTRL, i[0] ? 16'h000B : 16'h0003);
      cyc(3);
      chk("speed", exp_speed(n), 16'(spct));
      chk("torque", i[0] ? 16'(tq) : 16'h03FF, 16'(tlim));
      chk("monitor", 16'(spd[9:2]), 16'(mona));
      chk("monitor b", 16'(tq[9:2]), 16'(monb));
    end
    wr_reg(`PIO_REG_CTRL, 16'h0007);
    cyc(3);
    chk("shutoff flags", 16'h0000, {13'h0, trouble, rough, ready});
    complete_run();
  end
endmodule
`default_nettype wire
